// ### rtl/etcs_pkg.sv
// shared constants and carriers of the e1 transmit clock select block
package etcs_pkg;
   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [15:0] ETCS_CSR0_ADDR = 16'h0100;
   localparam logic [15:0] ETCS_CSR1_ADDR = 16'h1100;
   localparam logic [15:0] ETCS_STAT0_ADDR = 16'h0B00;
   localparam logic [15:0] ETCS_STAT1_ADDR = 16'h1B00;
   // ---------------------------------------------------------------
   // clock select field positions and reset value
   // ---------------------------------------------------------------
   localparam int ETCS_LCV_BIT = 7;
   localparam int ETCS_T1_BIT = 6;
   localparam int ETCS_FSE_BIT = 5;
   localparam int ETCS_CLP_BIT = 4;
   localparam int ETCS_SRC_LSB = 0;
   localparam logic [7:0] ETCS_CSR_RESET = 8'h11;
   localparam logic [1:0] ETCS_SRC_LINE_A = 2'h0;
   localparam logic [1:0] ETCS_SRC_SER = 2'h1;
   localparam logic [1:0] ETCS_SRC_PLL = 2'h2;
   localparam logic [1:0] ETCS_SRC_LINE_B = 2'h3;
   // ---------------------------------------------------------------
   // status field
   // ---------------------------------------------------------------
   localparam int ETCS_LOSS_BIT = 5;
   localparam logic [1:0] ETCS_LOSS_RESET = 2'h0;
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ETCS_USE_LINE = 3'b001,
      ETCS_USE_SER = 3'b010,
      ETCS_USE_PLL = 3'b100
   } etcs_src_t;

   typedef struct packed {
      logic line_clk;
      logic ser_clk;
      logic pll_clk;
      logic ref_8k;
      logic recovery_lost;
   } etcs_pins_t;

   typedef struct packed {
      logic tx_tick;
      logic frame_align;
      logic line_violation_insert;
      logic carrier_standard_select;
      etcs_src_t src;
   } etcs_tx_t;
endpackage

// ### rtl/etcs_chan.sv
// one channel: pin synchronisers, source mux, fallback, violation pulse
`timescale 1ns/1ps
module etcs_chan
   import etcs_pkg::*;
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // async reset, active low
   input wire logic [7:0] transmit_clock_select, // channel clock select value
   input wire logic fse, // global frame sync enable
   input wire etcs_pins_t pins, // asynchronous pin inputs
   output etcs_tx_t tx, // transmit timing controls
   output logic loss_event // clock loss while protected
);
   // ---------------------------------------------------------------
   // synchronisers and edge detect
   // ---------------------------------------------------------------
   logic [4:0] meta_reg;
   logic [4:0] sync_reg;
   logic [4:0] prev_reg;
   logic [4:0] rise;
   logic lcv_prev_reg;
   etcs_src_t src_next;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= 5'h00;
         sync_reg <= 5'h00;
         prev_reg <= 5'h00;
      end else begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end
   assign rise = sync_reg & ~prev_reg;

   function automatic etcs_src_t decode_src(input logic [1:0] sel);
      case (sel)
         ETCS_SRC_SER: decode_src = ETCS_USE_SER;
         ETCS_SRC_PLL: decode_src = ETCS_USE_PLL;
         default: decode_src = ETCS_USE_LINE;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // source choice with clock loss fallback
   // ---------------------------------------------------------------
   always_comb begin
      src_next = decode_src(transmit_clock_select[ETCS_SRC_LSB +: 2]);
      if (src_next == ETCS_USE_LINE && transmit_clock_select[ETCS_CLP_BIT] && sync_reg[0]) begin
         src_next = ETCS_USE_PLL;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx.src <= ETCS_USE_SER;
         tx.tx_tick <= 1'b0;
         tx.frame_align <= 1'b0;
         tx.carrier_standard_select <= 1'b0;
      end else begin
         tx.src <= src_next;
         case (src_next)
            ETCS_USE_LINE: tx.tx_tick <= rise[4];
            ETCS_USE_SER: tx.tx_tick <= rise[3];
            ETCS_USE_PLL: tx.tx_tick <= rise[2];
            default: tx.tx_tick <= 1'b0;
         endcase
         // alignment only under the pll source
         tx.frame_align <= fse && src_next == ETCS_USE_PLL && rise[1];
         tx.carrier_standard_select <= transmit_clock_select[ETCS_T1_BIT];
      end
   end

   // ---------------------------------------------------------------
   // single violation per rising edge of the insert bit
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lcv_prev_reg <= 1'b0;
         tx.line_violation_insert <= 1'b0;
      end else begin
         lcv_prev_reg <= transmit_clock_select[ETCS_LCV_BIT];
         tx.line_violation_insert <= transmit_clock_select[ETCS_LCV_BIT] && !lcv_prev_reg;
      end
   end

   // loss reported only with protection on and line source chosen
   assign loss_event = rise[0] && transmit_clock_select[ETCS_CLP_BIT]
      && decode_src(transmit_clock_select[ETCS_SRC_LSB +: 2]) == ETCS_USE_LINE;
endmodule // etcs_chan

// ### rtl/etcs_top.sv
// e1 transmit clock select: ahb-lite registers and two channels
`timescale 1ns/1ps
module etcs_top
   import etcs_pkg::*;
(
   input wire logic hclk, // system clock, 250 mhz
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [15:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready, always high
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire etcs_pins_t pins0, // channel 0 pins
   input wire etcs_pins_t pins1, // channel 1 pins
   output etcs_tx_t tx0, // channel 0 transmit controls
   output etcs_tx_t tx1 // channel 1 transmit controls
);
   // ---------------------------------------------------------------
   // bus decode
   // ---------------------------------------------------------------
   logic [7:0] csr0_reg;
   logic [7:0] csr1_reg;
   logic fse_reg;
   logic [1:0] loss_reg;
   logic [1:0] loss_event;
   logic wr_pend_reg;
   logic [15:0] wr_addr_reg;
   logic [31:0] rd_next;
   logic take;
   logic [7:0] csr1_view;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign take = hsel && htrans[1] && hready;
   assign csr1_view = {csr1_reg[7:6], fse_reg, csr1_reg[4:0]};

   function automatic logic is_addr(input logic [15:0] a,
                                    input logic [15:0] ref_a);
      is_addr = {a[15:2], 2'b00} == ref_a;
   endfunction

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 16'h0000;
      end else begin
         wr_pend_reg <= take && hwrite;
         if (take) begin
            wr_addr_reg <= haddr;
         end
      end
   end

   // ---------------------------------------------------------------
   // read path, data registered at the address phase
   // ---------------------------------------------------------------
   always_comb begin
      rd_next = 32'h0000_0000;
      if (is_addr(haddr, ETCS_CSR0_ADDR)) begin
         rd_next[7:0] = csr0_reg;
      end else if (is_addr(haddr, ETCS_CSR1_ADDR)) begin
         rd_next[7:0] = csr1_view;
      end else if (is_addr(haddr, ETCS_STAT0_ADDR)) begin
         rd_next[ETCS_LOSS_BIT] = loss_reg[0];
      end else if (is_addr(haddr, ETCS_STAT1_ADDR)) begin
         rd_next[ETCS_LOSS_BIT] = loss_reg[1];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         hrdata <= rd_next;
      end
   end

   // ---------------------------------------------------------------
   // clock select registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         csr0_reg <= ETCS_CSR_RESET;
         csr1_reg <= ETCS_CSR_RESET;
         fse_reg <= 1'b0;
      end else if (wr_pend_reg) begin
         if (is_addr(wr_addr_reg, ETCS_CSR0_ADDR)) begin
            csr0_reg <= hwdata[7:0];
            fse_reg <= hwdata[ETCS_FSE_BIT];
         end
         if (is_addr(wr_addr_reg, ETCS_CSR1_ADDR)) begin
            csr1_reg <= hwdata[7:0];
         end
      end
   end

   // ---------------------------------------------------------------
   // clock loss status, write one to clear, set wins
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         loss_reg <= ETCS_LOSS_RESET;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (loss_event[i]) begin
               loss_reg[i] <= 1'b1;
            end else if (wr_pend_reg && hwdata[ETCS_LOSS_BIT]
                && is_addr(wr_addr_reg, i == 0 ? ETCS_STAT0_ADDR
                                               : ETCS_STAT1_ADDR)) begin
               loss_reg[i] <= 1'b0;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   etcs_chan u_ch0 (
      .hclk(hclk),
      .hresetn(hresetn),
      .transmit_clock_select(csr0_reg),
      .fse(fse_reg),
      .pins(pins0),
      .tx(tx0),
      .loss_event(loss_event[0])
   );

   etcs_chan u_ch1 (
      .hclk(hclk),
      .hresetn(hresetn),
      .transmit_clock_select(csr1_reg),
      .fse(fse_reg),
      .pins(pins1),
      .tx(tx1),
      .loss_event(loss_event[1])
   );

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence lcv_rise_s;
      !csr0_reg[ETCS_LCV_BIT] ##1 csr0_reg[ETCS_LCV_BIT];
   endsequence

   sequence lcv_hold_s;
      csr0_reg[ETCS_LCV_BIT] [*3];
   endsequence

   AST_LCV_ONE: assert property (
      lcv_rise_s |=> tx0.line_violation_insert
      ##1 !tx0.line_violation_insert)
      else $error("violation not a single pulse after bit rise");
   AST_LCV_HOLD: assert property (
      lcv_hold_s |=> !tx0.line_violation_insert)
      else $error("violation repeated while bit held");
   AST_T1_MODE: assert property (
      tx1.carrier_standard_select == $past(csr1_reg[ETCS_T1_BIT]))
      else $error("standard select does not follow bit 6");
   AST_ALIGN_PLL: assert property (
      tx0.frame_align |-> tx0.src == ETCS_USE_PLL && $past(fse_reg))
      else $error("frame align without pll source or enable");
   AST_FSE_GLOBAL: assert property (
      tx1.frame_align |-> $past(fse_reg) && tx1.src == ETCS_USE_PLL)
      else $error("channel 1 aligned without global enable");
   AST_FSE_WRITE: assert property (
      wr_pend_reg && is_addr(wr_addr_reg, ETCS_CSR0_ADDR)
      |=> fse_reg == $past(hwdata[ETCS_FSE_BIT]))
      else $error("global frame sync not taken from channel 0 write");
   AST_FALLBACK: assert property (
      csr0_reg[1:0] == ETCS_SRC_LINE_A && csr0_reg[ETCS_CLP_BIT]
      && u_ch0.sync_reg[0] && $stable(csr0_reg)
      |=> tx0.src == ETCS_USE_PLL)
      else $error("no fallback to pll on recovery loss");
   AST_NO_PROTECT: assert property (
      csr0_reg[1:0] == ETCS_SRC_LINE_B && !csr0_reg[ETCS_CLP_BIT]
      && $stable(csr0_reg) |=> tx0.src == ETCS_USE_LINE)
      else $error("fallback with protection disabled");
   AST_LOSS_GATE: assert property (
      $rose(loss_reg[0]) |-> $past(csr0_reg[ETCS_CLP_BIT]))
      else $error("clock loss flagged without protection");
   AST_SRC_SER: assert property (
      csr1_reg[1:0] == ETCS_SRC_SER && $stable(csr1_reg)
      |=> tx1.src == ETCS_USE_SER)
      else $error("serial clock source not selected");
endmodule // etcs_top

// ### tb/etcs_liu_model.sv
// line interface model: recovered, serial and pll clocks, 300 ns period reference
`timescale 1ns/1ps
module etcs_liu_model
   import etcs_pkg::*;
(
   input wire logic lost, // clock recovery lost request
   output etcs_pins_t pins // clocks and status toward the block
);
   logic line_reg = 1'b0;
   logic ser_reg = 1'b0;
   logic pll_reg = 1'b0;
   logic ref_reg = 1'b0;
   logic lost_reg = 1'b0;
   // ---------------------------------------------------------------
   // clocks, unrelated to hclk
   // ---------------------------------------------------------------
   // recovered clock stands still while recovery is lost
   always begin
      #10.3;
      if (!lost_reg) line_reg = ~line_reg;
   end
   always #14.1 ser_reg = ~ser_reg;
   always #12.7 pll_reg = ~pll_reg;
   always #150.0 ref_reg = ~ref_reg;
   always @(lost) lost_reg <= #3.1 lost;
   assign pins = {line_reg, ser_reg, pll_reg, ref_reg, lost_reg};
endmodule // etcs_liu_model

// ### tb/e1_transmit_clock_select_bench.sv
// self-checking bench: ahb-lite register access and transmit controls
`timescale 1ns/1ps
module e1_transmit_clock_select_bench;
   import etcs_pkg::*;
   logic hclk = 1'b0;
   logic hresetn, hsel, hwrite, lost0, lost1;
   logic [15:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rdv;
   wire logic hreadyout, hresp;
   etcs_pins_t pins0, pins1;
   etcs_tx_t tx0, tx1;
   int bad_count = 0, checks_done = 0, cyc = 0;
   int vc0 = 0, vc1 = 0, fa0 = 0, fa1 = 0, tk0 = 0, s0, s1;
   etcs_src_t expd [4] = '{ETCS_USE_LINE, ETCS_USE_SER, ETCS_USE_PLL,
                           ETCS_USE_LINE};
   always #2 hclk = ~hclk;
   etcs_top etcs_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pins0(pins0), .pins1(pins1),
      .tx0(tx0), .tx1(tx1));
   etcs_liu_model liu0_inst (.lost(lost0), .pins(pins0));
   etcs_liu_model liu1_inst (.lost(lost1), .pins(pins1));
   // ---------------------------------------------------------------
   // pulse counters and timeout
   // ---------------------------------------------------------------
   always @(posedge hclk) begin
      if (tx0.line_violation_insert === 1'b1) vc0++;
      if (tx1.line_violation_insert === 1'b1) vc1++;
      if (tx0.frame_align === 1'b1) fa0++;
      if (tx1.frame_align === 1'b1) fa1++;
      if (tx0.tx_tick === 1'b1) tk0++;
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         close_out();
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic close_out();
      $display("mismatches %0d, checks %0d", bad_count, checks_done);
      if (bad_count == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [15:0] a,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rdv = hrdata;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      xfer(1'b1, a, {24'h00_0000, d});
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      chk(rdv, exp);
   endtask
   task automatic frames(input int e0, input int e1);
      // let pulses launched under the old setting drain first
      repeat (3) @(posedge hclk);
      s0 = fa0;
      s1 = fa1;
      repeat (200) @(posedge hclk);
      chk(32'(fa0 != s0), 32'(e0));
      chk(32'(fa1 != s1), 32'(e1));
   endtask
   task automatic src_is(input etcs_src_t e);
      repeat (8) @(posedge hclk);
      chk({29'h0, tx0.src}, {29'h0, e});
   endtask
   // ---------------------------------------------------------------
   // main sequence; bits 3:2 are always written as zero
   // ---------------------------------------------------------------
   initial begin
      {hsel, hwrite, lost0, lost1, hresetn} = 5'h00;
      haddr = 16'h0000;
      htrans = 2'b00;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      rd(ETCS_CSR0_ADDR, 32'h0000_0011);
      rd(ETCS_STAT0_ADDR, 32'h0000_0000);
      rd(16'h0200, 32'h0000_0000);
      src_is(ETCS_USE_SER);
      for (int i = 0; i < 4; i++) begin
         wr(ETCS_CSR0_ADDR, 8'h10 | 8'(i));
         src_is(expd[i]);
      end
      wr(ETCS_CSR1_ADDR, 8'h52);
      repeat (6) @(posedge hclk);
      chk({31'h0, tx1.carrier_standard_select}, 32'h0000_0001);
      chk({31'h0, tx0.carrier_standard_select}, 32'h0000_0000);
      wr(ETCS_CSR0_ADDR, 8'h32);
      rd(ETCS_CSR1_ADDR, 32'h0000_0072);
      frames(1, 1);
      wr(ETCS_CSR1_ADDR, 8'h52);
      rd(ETCS_CSR1_ADDR, 32'h0000_0072);
      wr(ETCS_CSR0_ADDR, 8'h31);
      frames(0, 1);
      wr(ETCS_CSR0_ADDR, 8'h12);
      frames(0, 0);
      s0 = vc0;
      wr(ETCS_CSR0_ADDR, 8'h92);
      wr(ETCS_CSR0_ADDR, 8'h92);
      repeat (10) @(posedge hclk);
      chk(32'(vc0 - s0), 32'h0000_0001);
      wr(ETCS_CSR0_ADDR, 8'h12);
      wr(ETCS_CSR0_ADDR, 8'h92);
      repeat (10) @(posedge hclk);
      chk(32'(vc0 - s0), 32'h0000_0002);
      chk(32'(vc1), 32'h0000_0000);
      wr(ETCS_CSR0_ADDR, 8'h10);
      lost0 <= 1'b1;
      src_is(ETCS_USE_PLL);
      s0 = tk0;
      repeat (20) @(posedge hclk);
      chk(32'(tk0 != s0), 32'h0000_0001);
      rd(ETCS_STAT0_ADDR, 32'h0000_0020);
      rd(ETCS_STAT1_ADDR, 32'h0000_0000);
      wr(ETCS_STAT0_ADDR, 8'h20);
      rd(ETCS_STAT0_ADDR, 32'h0000_0000);
      lost0 <= 1'b0;
      src_is(ETCS_USE_LINE);
      wr(ETCS_CSR0_ADDR, 8'h03);
      lost0 <= 1'b1;
      src_is(ETCS_USE_LINE);
      s0 = tk0;
      repeat (20) @(posedge hclk);
      chk(32'(tk0 - s0), 32'h0000_0000);
      rd(ETCS_STAT0_ADDR, 32'h0000_0000);
      lost0 <= 1'b0;
      chk({31'h0, hresp}, 32'h0000_0000);
      // second reset in mid-run restores the defaults
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(hrdata, 32'h0000_0000);
      hresetn <= 1'b1;
      rd(ETCS_CSR0_ADDR, 32'h0000_0011);
      src_is(ETCS_USE_SER);
      close_out();
   end
endmodule // e1_transmit_clock_select_bench
